// *** touch_adc_map.vh ***
// Register offsets, field positions, reset values and timing for the touch/converter block
`ifndef TOUCH_ADC_MAP_VH
`define TOUCH_ADC_MAP_VH

`define REG_IRQ_RISE      4'h2
`define REG_IRQ_FALL      4'h3
`define REG_TOUCH_CTRL    4'h9
`define REG_CONV_CTRL     4'hA
`define REG_CONV_DATA     4'hB

`define IRQ_TOUCH_BIT     0
`define IRQ_CONV_BIT      1

`define TC_POWER_LSB      0
`define TC_GROUND_LSB     4
`define TC_MODE_LSB       8
`define TC_BIAS_BIT       10
`define TC_XP_STAT_BIT    11
`define TC_XM_STAT_BIT    12

`define CC_ENABLE_BIT     0
`define CC_SYNC_BIT       1
`define CC_INPUT_LSB      2
`define CC_START_BIT      7

`define CD_VALID_BIT      15

`define MODE_INTERRUPT    2'h0
`define MODE_PRESSURE     2'h1

`define MUX_CURRENT_MON   4'h8

`define RST_IRQ_EN        2'h0
`define RST_TOUCH_CTRL    16'h0000
`define RST_CONV_CTRL     16'h0000

`define SETTLE_NS         2000
`define CLK_PERIOD_NS     4
`define SETTLE_CYCLES     ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** touch_panel_adc_control.v ***
// Touch panel terminal control, panel interrupts and converter start/result logic
//
// Functional notes
// - Each of four panel terminals set floating, powered or grounded independently.
// - Terminal both powered and grounded is detected and driven grounded.
// - Interrupt mode: press interrupts if fall enabled, release if rise enabled.
// - Press and release detection keeps working in stand-by.
// - Mode 00 interrupt, 01 pressure with current monitor, 10/11 position.
// - Mode and terminal setup live in control register 9.
// - Multiplexer picks one source among 4 inputs, 4 terminals, pressure; 10-bit results.
// - Converter powered only while enable bit in register 10 is set.
// - Completed result is placed in register 11.
// - No conversion starts while X plate is in interrupt mode; code checks mode only at the start request.
// - Sync enable clear: start bit 0->1 begins conversion directly.
// - Sync enable set: conversion begins on external sync rising edge.
// - Selection change in the start frame delays start for settling.
// - Result readable next frame, or second frame after a selection change.
// - Sync mode: start arms, first sync edge after settling starts.
// - Start or arm clears result to 0x000 and valid; completion sets both.
// - Conversion completion interrupt with separate rise and fall enables.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_map.vh"

module touch_panel_adc_control #(
   parameter RES_W         = 10,
   parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input  wire             i_ref_clk,
   input  wire             i_nrst,
   input  wire [3:0]       i_addr,
   input  wire [15:0]      i_wdata,
   input  wire             i_wr,
   input  wire             i_rd,
   output reg  [15:0]      o_rdata,
   input  wire             i_frame_sync,
   input  wire             i_x_plus_terminal,
   input  wire             i_x_minus_terminal,
   input  wire             i_ext_sync_pin,
   output wire [3:0]       o_term_power,
   output wire [3:0]       o_term_ground,
   output wire             o_res_bias,
   output wire             o_bias_enable,
   output wire [3:0]       o_mux_sel,
   output wire             o_conv_enable,
   output wire             o_track_enable,
   output reg              o_conv_start,
   input  wire             i_conv_done,
   input  wire [RES_W-1:0] i_conv_data,
   output reg              o_touch_irq,
   output reg              o_conv_irq
);

   localparam ST_IDLE   = 2'h0;
   localparam ST_SETTLE = 2'h1;
   localparam ST_ARMED  = 2'h2;
   localparam ST_CONV   = 2'h3;

   localparam CNT_W = 16;

   // Reset release
   reg              rst_a_r;
   reg              rst_b_r;
   wire             rst_n;

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_a_r <= 1'b0;
         rst_b_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_b_r <= rst_a_r;
      end
   end
   assign rst_n = rst_b_r;

   // Pin synchronisers; stage one feeds only stage two
   reg [2:0]        pin_a_r;
   reg [2:0]        pin_b_r;
   reg [2:0]        pin_c_r;

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_r <= 3'h3;
         pin_b_r <= 3'h3;
         pin_c_r <= 3'h3;
      end else begin
         pin_a_r <= {i_ext_sync_pin, i_x_minus_terminal, i_x_plus_terminal};
         pin_b_r <= pin_a_r;
         pin_c_r <= pin_b_r;
      end
   end

   wire             xp_s;
   wire             xm_s;
   wire             sync_rise;
   wire             x_level;
   wire             x_level_d;

   assign xp_s      = pin_b_r[0];
   assign xm_s      = pin_b_r[1];
   assign sync_rise = pin_b_r[2] & ~pin_c_r[2];
   // Plate reads high only while both terminals stay high (no press)
   assign x_level   = pin_b_r[0] & pin_b_r[1];
   assign x_level_d = pin_c_r[0] & pin_c_r[1];

   // Control registers
   reg [1:0]        irq_rise_r;
   reg [1:0]        irq_fall_r;
   reg [7:0]        term_r;
   reg [1:0]        mode_r;
   reg              bias_r;
   reg              enable_r;
   reg              sync_en_r;
   reg [2:0]        input_r;
   reg              start_r;
   reg [RES_W-1:0]  result_r;
   reg              valid_r;
   reg              mux_chg_r;
   reg [1:0]        state_r;
   reg [CNT_W-1:0]  cnt_r;

   wire             wr_touch;
   wire             wr_conv;
   wire [1:0]       mode_nxt;
   wire [2:0]       input_nxt;
   wire [3:0]       mux_nxt;
   wire [3:0]       mux_cur;
   wire             mux_change;
   wire             start_edge;
   wire             x_intr_mode;
   wire             start_ok;

   assign wr_touch = i_wr && (i_addr == `REG_TOUCH_CTRL);
   assign wr_conv  = i_wr && (i_addr == `REG_CONV_CTRL);

   // Pressure mode hands the converter the current monitor
   function [3:0] mux_of;
      input [1:0] md;
      input [2:0] sel;
      begin
         if (md == `MODE_PRESSURE)
            mux_of = `MUX_CURRENT_MON;
         else
            mux_of = {1'b0, sel};
      end
   endfunction

   assign mode_nxt  = wr_touch ? i_wdata[`TC_MODE_LSB +: 2] : mode_r;
   assign input_nxt = wr_conv ? i_wdata[`CC_INPUT_LSB +: 3] : input_r;
   assign mux_cur   = mux_of(mode_r, input_r);
   assign mux_nxt   = mux_of(mode_nxt, input_nxt);
   assign mux_change = (mux_nxt != mux_cur);

   assign start_edge  = wr_conv && i_wdata[`CC_START_BIT] && !start_r;
   assign x_intr_mode = (mode_nxt == `MODE_INTERRUPT);
   // The enable in the same write counts, so enable-and-start works
   assign start_ok    = start_edge && !x_intr_mode
                        && (wr_conv ? i_wdata[`CC_ENABLE_BIT] : enable_r);

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_rise_r <= `RST_IRQ_EN;
         irq_fall_r <= `RST_IRQ_EN;
         term_r     <= 8'h00;
         mode_r     <= 2'h0;
         bias_r     <= 1'b0;
         enable_r   <= 1'b0;
         sync_en_r  <= 1'b0;
         input_r    <= 3'h0;
         start_r    <= 1'b0;
      end else begin
         if (i_wr && (i_addr == `REG_IRQ_RISE))
            irq_rise_r <= i_wdata[1:0];
         if (i_wr && (i_addr == `REG_IRQ_FALL))
            irq_fall_r <= i_wdata[1:0];
         if (wr_touch) begin
            term_r <= i_wdata[7:0];
            mode_r <= mode_nxt;
            bias_r <= i_wdata[`TC_BIAS_BIT];
         end
         if (wr_conv) begin
            enable_r  <= i_wdata[`CC_ENABLE_BIT];
            sync_en_r <= i_wdata[`CC_SYNC_BIT];
            input_r   <= input_nxt;
            start_r   <= i_wdata[`CC_START_BIT];
         end
      end
   end

   // Selection changed during the current frame; a change wins over frame sync
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n)
         mux_chg_r <= 1'b0;
      else if ((wr_touch || wr_conv) && mux_change)
         mux_chg_r <= 1'b1;
      else if (i_frame_sync)
         mux_chg_r <= 1'b0;
   end

   // Terminal drive; grounding wins a conflict
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_term
         assign o_term_ground[g] = term_r[`TC_GROUND_LSB + g];
         assign o_term_power[g]  = term_r[`TC_POWER_LSB + g]
                                   & ~term_r[`TC_GROUND_LSB + g];
      end
   endgenerate

   assign o_res_bias    = (mode_r == `MODE_INTERRUPT);
   // Left to software in interrupt mode; forcing it off would hide misuse
   assign o_bias_enable = bias_r;
   assign o_mux_sel     = mux_cur;
   assign o_conv_enable = enable_r;

   // Start sequencer
   reg [1:0]        state_nxt;
   reg [CNT_W-1:0]  cnt_nxt;
   reg              start_nxt;
   reg              clear_res;
   reg              take_res;

   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      start_nxt = 1'b0;
      clear_res = 1'b0;
      take_res  = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (start_ok) begin
               clear_res = 1'b1;
               if (mux_chg_r || mux_change) begin
                  state_nxt = ST_SETTLE;
                  cnt_nxt   = SETTLE_CYCLES[CNT_W-1:0];
               end else if (wr_conv ? i_wdata[`CC_SYNC_BIT] : sync_en_r) begin
                  state_nxt = ST_ARMED;
               end else begin
                  state_nxt = ST_CONV;
                  start_nxt = 1'b1;
               end
            end
         end
         ST_SETTLE: begin
            // Sync edges while settling are dropped
            if (cnt_r > 1) begin
               cnt_nxt = cnt_r - 1'b1;
            end else if (sync_en_r) begin
               state_nxt = ST_ARMED;
               cnt_nxt   = {CNT_W{1'b0}};
            end else begin
               state_nxt = ST_CONV;
               start_nxt = 1'b1;
               cnt_nxt   = {CNT_W{1'b0}};
            end
         end
         ST_ARMED: begin
            if (sync_rise) begin
               state_nxt = ST_CONV;
               start_nxt = 1'b1;
            end
         end
         ST_CONV: begin
            if (i_conv_done) begin
               state_nxt = ST_IDLE;
               take_res  = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Dropping the enable powers the converter down mid-sequence
      if (!enable_r && state_r != ST_IDLE) begin
         state_nxt = ST_IDLE;
         start_nxt = 1'b0;
         take_res  = 1'b0;
      end
   end

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= ST_IDLE;
         cnt_r        <= {CNT_W{1'b0}};
         o_conv_start <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         o_conv_start <= start_nxt;
      end
   end

   assign o_track_enable = enable_r && (state_r != ST_IDLE);

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= {RES_W{1'b0}};
         valid_r  <= 1'b0;
      end else if (take_res) begin
         result_r <= i_conv_data;
         valid_r  <= 1'b1;
      end else if (clear_res) begin
         result_r <= {RES_W{1'b0}};
         valid_r  <= 1'b0;
      end
   end

   // Event pulses; no clock gating so detection runs in stand-by
   wire             press;
   wire             release_ev;

   assign press      = x_level_d & ~x_level;
   assign release_ev = ~x_level_d & x_level;

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_touch_irq <= 1'b0;
         o_conv_irq  <= 1'b0;
      end else begin
         o_touch_irq <= (mode_r == `MODE_INTERRUPT)
                        && ((press && irq_fall_r[`IRQ_TOUCH_BIT])
                        || (release_ev && irq_rise_r[`IRQ_TOUCH_BIT]));
         o_conv_irq  <= (take_res && !valid_r && irq_rise_r[`IRQ_CONV_BIT])
                        || (clear_res && valid_r && irq_fall_r[`IRQ_CONV_BIT]);
      end
   end

   // Read port; unmapped offsets read zero
   reg [15:0]       rd_mux;

   always @* begin
      rd_mux = 16'h0000;
      case (i_addr)
         `REG_IRQ_RISE:   rd_mux[1:0] = irq_rise_r;
         `REG_IRQ_FALL:   rd_mux[1:0] = irq_fall_r;
         `REG_TOUCH_CTRL: begin
            rd_mux[7:0]              = term_r;
            rd_mux[`TC_MODE_LSB +: 2] = mode_r;
            rd_mux[`TC_BIAS_BIT]     = bias_r;
            rd_mux[`TC_XP_STAT_BIT]  = xp_s;
            rd_mux[`TC_XM_STAT_BIT]  = xm_s;
         end
         `REG_CONV_CTRL: begin
            rd_mux[`CC_ENABLE_BIT]     = enable_r;
            rd_mux[`CC_SYNC_BIT]       = sync_en_r;
            rd_mux[`CC_INPUT_LSB +: 3] = input_r;
            rd_mux[`CC_START_BIT]      = start_r;
         end
         `REG_CONV_DATA: begin
            rd_mux[RES_W-1:0]     = result_r;
            rd_mux[`CD_VALID_BIT] = valid_r;
         end
         default: rd_mux = 16'h0000;
      endcase
   end

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n)
         o_rdata <= 16'h0000;
      else if (i_rd)
         o_rdata <= rd_mux;
      else
         o_rdata <= 16'h0000;
   end

endmodule
`default_nettype wire

// *** touch_ctl_assertions.sv ***
// Port assertions for the touch panel and converter control block
`timescale 1ns/1ps
`default_nettype none
module touch_ctl_checker #(
   parameter RES_W = 10
) (
   input wire logic             i_ref_clk,
   input wire logic             i_nrst,
   input wire logic [3:0]       i_addr,
   input wire logic             i_rd,
   input wire logic [15:0]      o_rdata,
   input wire logic [3:0]       o_term_power,
   input wire logic [3:0]       o_term_ground,
   input wire logic             o_res_bias,
   input wire logic [3:0]       o_mux_sel,
   input wire logic             o_conv_enable,
   input wire logic             o_track_enable,
   input wire logic             o_conv_start,
   input wire logic             i_conv_done,
   input wire logic [RES_W-1:0] i_conv_data,
   input wire logic             o_touch_irq,
   input wire logic             o_conv_irq
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   ground_wins_a: assert property ((o_term_power & o_term_ground) == 4'h0)
      else $error("terminal powered and grounded");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside its slot");
   result_load_a: assert property ($past(i_rd) && $past(i_addr) == 4'hB
      && $past(i_conv_done, 2) |-> o_rdata[15] && o_rdata[RES_W-1:0] == $past(i_conv_data, 2))
      else $error("result not stored");
   start_en_a: assert property (o_conv_start |-> o_conv_enable)
      else $error("start with converter off");
   track_off_a: assert property (!o_conv_enable |-> !o_track_enable)
      else $error("tracking with converter off");
   start_pulse_a: assert property (o_conv_start |-> !o_res_bias ##1 !o_conv_start)
      else $error("bad start pulse");
   touch_pulse_a: assert property (o_touch_irq |-> o_res_bias ##1 !o_touch_irq)
      else $error("bad panel alert");
   conv_irq_a: assert property ($rose(o_conv_irq) |=> $fell(o_conv_irq))
      else $error("bad conversion alert");
   mux_range_a: assert property (o_mux_sel <= 4'h8)
      else $error("no such source");
   pressure_mux_a: assert property (o_mux_sel == 4'h8 |-> !o_res_bias)
      else $error("monitor picked in alert mode");
endmodule
bind touch_panel_adc_control touch_ctl_checker #(.RES_W(RES_W)) touch_ctl_checker_inst (
   .i_ref_clk, .i_nrst, .i_addr, .i_rd, .o_rdata, .o_term_power, .o_term_ground,
   .o_res_bias, .o_mux_sel, .o_conv_enable, .o_track_enable, .o_conv_start,
   .i_conv_done, .i_conv_data, .o_touch_irq, .o_conv_irq);
`default_nettype wire

// *** panel_model.sv ***
// Stand-in for the panel terminals, the sync source and the converter core
`timescale 1ns/1ps
`default_nettype none
module panel_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_start,
   input  wire logic       i_press,
   input  wire logic       i_sync_req,
   input  wire logic [3:0] i_lat,
   input  wire logic [9:0] i_data,
   output wire logic       o_x_plus,
   output wire logic       o_x_minus,
   output wire logic       o_ext_sync,
   output var  logic       o_done,
   output var  logic [9:0] o_data
);
   logic [3:0] cnt = 4'h0;
   // Plates held up by the bias resistor; a press pulls both X terminals low
   assign o_x_plus = !i_press;
   assign o_x_minus = !i_press;
   assign o_ext_sync = i_sync_req;
   initial begin
      o_done = 1'b0;
      o_data = 10'h2AA;
   end
   always @(posedge i_ref_clk) begin
      o_done <= 1'b0;
      // Data mean nothing away from done, so they toggle to expose late sampling
      o_data <= ~o_data;
      if (i_start)
         cnt <= i_lat;
      else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1) begin
            o_done <= 1'b1;
            o_data <= i_data;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the touch panel and converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int SETTLE = 5;
   logic        i_ref_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
   logic        i_frame_sync = 1'b0, press = 1'b0, sync_req = 1'b0;
   logic [3:0]  i_addr = 4'h0, lat = 4'h8;
   logic [15:0] i_wdata = 16'h0000, seed = 16'h0058;
   logic [9:0]  cdata = 10'h000;
   logic [15:0] q[$];
   logic [3:0]  regs [6] = '{4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'h5};
   int          num_errors = 0, num_checks = 0, cs = 0, ci = 0;
   wire [15:0]  o_rdata;
   wire [9:0]   i_conv_data;
   wire [3:0]   o_term_power, o_term_ground, o_mux_sel;
   wire         i_x_plus_terminal, i_x_minus_terminal, i_ext_sync_pin, i_conv_done;
   wire         o_res_bias, o_bias_enable, o_conv_enable, o_track_enable;
   wire         o_conv_start, o_touch_irq, o_conv_irq;
   wire [2:0]   ev = {o_touch_irq, i_conv_done, o_conv_start};
   always #2 i_ref_clk = ~i_ref_clk;
   touch_panel_adc_control #(.SETTLE_CYCLES(SETTLE)) touch_panel_adc_control_inst (
      .i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_frame_sync,
      .i_x_plus_terminal, .i_x_minus_terminal, .i_ext_sync_pin, .o_term_power,
      .o_term_ground, .o_res_bias, .o_bias_enable, .o_mux_sel, .o_conv_enable,
      .o_track_enable, .o_conv_start, .i_conv_done, .i_conv_data, .o_touch_irq, .o_conv_irq);
   panel_model panel_model_inst (
      .i_ref_clk, .i_start(o_conv_start), .i_press(press), .i_sync_req(sync_req),
      .i_lat(lat), .i_data(cdata), .o_x_plus(i_x_plus_terminal),
      .o_x_minus(i_x_minus_terminal), .o_ext_sync(i_ext_sync_pin), .o_done(i_conv_done),
      .o_data(i_conv_data));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // A read notes its expected word; the monitor below compares it a cycle later
   task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= wr;
      i_rd <= !wr;
      i_addr <= a;
      i_wdata <= d;
      if (!wr)
         q.push_back(d);
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
   endtask
   always @(posedge i_ref_clk) begin
      rd_d <= i_rd;
      cs <= cs + o_conv_start;
      ci <= ci + o_conv_irq;
   end
   always @(negedge i_ref_clk) begin
      if (rd_d)
         check(o_rdata, q.pop_front());
   end
   task automatic await(input int b, input int lim, input bit must, output int n);
      for (n = 1; n <= lim; n++) begin
         @(negedge i_ref_clk);
         if (ev[b])
            return;
      end
      if (must) begin
         check(16'h0000, 16'h0001);
         complete_run();
      end
   endtask
   task automatic frame;
      @(posedge i_ref_clk);
      i_frame_sync <= 1'b1;
      @(posedge i_ref_clk);
      i_frame_sync <= 1'b0;
   endtask
   task automatic go(input logic [15:0] v);
      seed = lfsr(seed);
      cdata <= seed[9:0];
      bus(1, 4'hA, v);
   endtask
   // Read straight after done so the stored word is seen at the first chance
   task automatic collect;
      int n;
      int c;
      c = ci;
      await(1, 40, 1, n);
      bus(0, 4'hB, {6'h20, cdata});
      @(negedge i_ref_clk);
      check(16'(ci - c), 16'h0001);
   endtask
   initial begin
      int n;
      int c;
      logic [15:0] d;
      logic [15:0] v;
      repeat (6) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      bus(1, 4'h5, 16'hFFFF);
      foreach (regs[k])
         bus(0, regs[k], (regs[k] == 4'h9) ? 16'h1800 : 16'h0000);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d = seed & 16'h07FF;
         d[9:8] = i[1:0];
         d[10] = d[10] & (i[1:0] != 2'h0);
         v = {11'h000, seed[12:10], 2'h1};
         bus(1, 4'hA, v);
         bus(1, 4'h9, d);
         @(negedge i_ref_clk);
         check({7'h00, o_bias_enable, o_term_power, o_term_ground},
               {7'h00, d[10], d[3:0] & ~d[7:4], d[7:4]});
         check({11'h000, o_res_bias, o_mux_sel},
               {11'h000, i[1:0] == 2'h0, (i[1:0] == 2'h1) ? 4'h8 : {1'b0, v[4:2]}});
         bus(0, 4'h9, {3'h0, 2'h3, d[10:0]});
      end
      bus(1, 4'h9, 16'h0621);
      bus(1, 4'hA, 16'h0005);
      bus(1, 4'h2, 16'h0002);
      frame();
      go(16'h0085);
      @(negedge i_ref_clk);
      check({13'h0000, o_conv_enable, o_track_enable, o_conv_start}, 16'h0007);
      bus(0, 4'hB, 16'h0000);
      collect();
      // New input chosen in the same frame as the start
      bus(1, 4'hA, 16'h0005);
      lat = 4'h2;
      go(16'h0089);
      await(0, 40, 1, n);
      check(16'(n), 16'(SETTLE + 1));
      collect();
      frame();
      bus(1, 4'hA, 16'h000B);
      lat = 4'hF;
      go(16'h008B);
      await(0, 12, 0, n);
      check(16'(n > 12), 16'h0001);
      bus(0, 4'hB, 16'h0000);
      sync_req <= 1'b1;
      await(0, 10, 1, n);
      @(posedge i_ref_clk);
      sync_req <= 1'b0;
      collect();
      bus(1, 4'hA, 16'h0000);
      c = cs;
      bus(1, 4'hA, 16'h0080);
      bus(1, 4'h9, 16'h00C3);
      bus(1, 4'hA, 16'h0001);
      bus(1, 4'hA, 16'h0081);
      repeat (12) @(negedge i_ref_clk);
      check(16'(cs - c), 16'h0000);
      bus(0, 4'hB, {6'h20, cdata});
      bus(1, 4'h3, 16'h0001);
      bus(1, 4'h2, 16'h0001);
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            bus(1, 4'h3, 16'h0000);
            bus(1, 4'h2, 16'h0000);
         end
         @(posedge i_ref_clk);
         press <= !press;
         await(2, 12, 0, n);
         check(16'(n <= 12), 16'(k < 2));
         bus(0, 4'h9, press ? 16'h00C3 : 16'h18C3);
      end
      complete_run();
   end
endmodule
`default_nettype wire
